// ===== hdl/spt_defs.svh
// Constants for the serial pattern trigger: offsets, fields, reset values and counts.
// Notes on behaviour
// RULE1: Serial bits enter position 15, shift toward 0.
// RULE2: Trigger word: each position one, zero or ignored.
// RULE3: Low-position patterns recognise five bit clocks later.
// RULE4: Framing qualifier admits matches only at frame point.
// RULE5: Frame offset counts from zero: N gives N+1.
// RULE6: Trigger waits delay bit clocks, 1 to 999999.
// RULE7: Shift, compare and delay run at 20 MHz.
// RULE8: Framing edge restarts count; trigger lasts one clock.
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define SPT_ADDR_W          5
`define SPT_REG_CTRL        5'h00
`define SPT_REG_CARE        5'h04
`define SPT_REG_VALUE       5'h08
`define SPT_REG_OFFSET      5'h0C
`define SPT_REG_DELAY       5'h10
`define SPT_REG_STATUS      5'h14
`define SPT_REG_COUNT       5'h18

// Field positions.
`define SPT_CTRL_QUAL_BIT   0
`define SPT_CTRL_ARM_BIT    1
`define SPT_STAT_BUSY_BIT   0
`define SPT_STAT_TRIG_BIT   1

// Reset values.
`define SPT_CTRL_RST        2'h0
`define SPT_CARE_RST        16'h0000
`define SPT_VALUE_RST       16'h0000
`define SPT_OFFSET_RST      8'h00
`define SPT_DELAY_RST       20'h0_0001
`define SPT_COUNT_RST       16'h0000

// Shift register and delay limits.
`define SPT_POS_TOP         15
`define SPT_LOW_LAG         5
`define SPT_DELAY_MIN       20'h0_0001
`define SPT_DELAY_MAX       20'hF_423F

// Timing: the highest bit rate and the register clock, both in MHz.
`define SPT_BIT_RATE_MAX_MHZ 20
`define SPT_CLK_MHZ          20

`endif

// ===== hdl/spt_pkg.sv
// Types shared by the serial pattern trigger modules.
package spt_pkg;

   // Frame offset counter: waiting for a framing edge, or counting bits after one.
   typedef enum logic [0:0] {
      SPT_FRM_WAIT  = 1'b0,
      SPT_FRM_COUNT = 1'b1
   } spt_frm_state_t;

   // Trigger delay counter: idle, or counting bit clocks towards the pulse.
   typedef enum logic [0:0] {
      SPT_DLY_IDLE = 1'b0,
      SPT_DLY_RUN  = 1'b1
   } spt_dly_state_t;

endpackage : spt_pkg

// ===== hdl/spt_sync.sv
// Three-stage level synchroniser with agreement filter.
`timescale 1ns/100ps
module spt_sync (
   input  wire logic clk,   // Destination clock.
   input  wire logic d,     // Level from another domain.
   output logic      q      // Filtered level in this domain.
);
   logic s1;
   logic s2;
   logic s3;
   logic next_q;

   // Only the second stage reads the first; q moves once stages two and three agree.
   always_comb begin
      next_q = (s2 == s3) ? s3 : q;
   end

   always_ff @(posedge clk) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
   end
endmodule : spt_sync

// ===== hdl/spt_delay.sv
// Bit-clock delay counter that turns a recognition into one trigger pulse.
`timescale 1ns/100ps
`include "spt_defs.svh"
module spt_delay
   import spt_pkg::*;
(
   input  wire logic        clk,     // Bit clock.
   input  wire logic        reset,   // Synchronous reset in the bit clock domain.
   input  wire logic        start,   // Recognition pulse.
   input  wire logic [19:0] delay,   // Bit clocks from recognition to trigger.
   output logic             trig     // One-bit-clock trigger pulse.
);
   spt_dly_state_t state;
   spt_dly_state_t next_state;
   logic [19:0]    cnt;
   logic [19:0]    next_cnt;
   logic           next_trig;
   logic [19:0]    eff;

   // A zero setting behaves as one; recognitions during a run are ignored.
   always_comb begin
      eff        = (delay < `SPT_DELAY_MIN) ? `SPT_DELAY_MIN : delay;
      next_state = state;
      next_cnt   = cnt;
      next_trig  = 1'b0;
      case (state)
         SPT_DLY_IDLE: begin
            if (start) begin
               next_trig = (eff == `SPT_DELAY_MIN);             // see RULE6
               next_cnt  = eff - `SPT_DELAY_MIN;
               if (eff != `SPT_DELAY_MIN) begin
                  next_state = SPT_DLY_RUN;
               end
            end
         end
         SPT_DLY_RUN: begin
            next_cnt = cnt - `SPT_DELAY_MIN;                    // see RULE6
            if (cnt == `SPT_DELAY_MIN) begin
               next_trig  = 1'b1;                               // see RULE8
               next_state = SPT_DLY_IDLE;
            end
         end
         default: begin
            next_state = SPT_DLY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= SPT_DLY_IDLE;
         cnt   <= 20'h0_0000;
         trig  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         trig  <= next_trig;
      end
   end

   // Helper: bit clocks elapsed since the accepted recognition.
   logic [19:0] since;
   logic [19:0] want;
   always_ff @(posedge clk) begin
      if (reset) begin
         since <= 20'h0_0000;
         want  <= 20'h0_0000;
      end else if (start && state == SPT_DLY_IDLE) begin
         since <= 20'h0_0001;
         want  <= eff;
      end else begin
         since <= since + 20'h0_0001;
      end
   end

   chk_delay_count: assert property (@(posedge clk) disable iff (reset) // see RULE6
      trig |-> (since == want))
      else $error("trigger pulse not at the programmed delay");

   chk_pulse_width: assert property (@(posedge clk) disable iff (reset) // see RULE8
      trig |=> !trig)
      else $error("trigger pulse longer than one bit clock");
endmodule : spt_delay

// ===== hdl/spt_trigger.sv
// Serial pattern trigger: Avalon-MM register file and bit-clock recogniser.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "spt_defs.svh"
module spt_trigger
   import spt_pkg::*;
(
   input  wire logic                   clk,             // Register clock, 20 MHz.
   input  wire logic                   reset,           // Synchronous reset, active high.
   input  wire logic [`SPT_ADDR_W-1:0] avs_address,     // Byte address.
   input  wire logic                   avs_read,        // Read request.
   input  wire logic                   avs_write,       // Write request.
   input  wire logic [31:0]            avs_writedata,   // Write data.
   output logic      [31:0]            avs_readdata,    // Read data, registered.
   output logic                        avs_waitrequest, // Stall the master.
   input  wire logic                   bit_clk,         // Serial bit clock from the source.
   input  wire logic                   serial_data,     // Serial data, valid at bit_clk rise.
   input  wire logic                   framing_pulse,   // One pulse per serial character.
   output logic                        trigger_out      // Trigger to the instrument.
);

   // Configuration-address decode used by the write stall and the write path's request toggle.
   function automatic logic spt_is_cfg(input logic [`SPT_ADDR_W-1:0] a);
      spt_is_cfg = (a == `SPT_REG_CTRL) || (a == `SPT_REG_CARE) || (a == `SPT_REG_VALUE) ||
                   (a == `SPT_REG_OFFSET) || (a == `SPT_REG_DELAY);
   endfunction : spt_is_cfg

   // True when every compared position of the word equals the wanted value.
   function automatic logic spt_hit(input logic [15:0] word, input logic [15:0] want,
                                    input logic [15:0] care);
      spt_hit = (((word ^ want) & care) == 16'h0000);
   endfunction : spt_hit

   // ------------------------------------------------------------------
   // Register clock domain.
   // ------------------------------------------------------------------
   logic [1:0]  ctrl;
   logic [15:0] care;
   logic [15:0] value;
   logic [7:0]  offset;
   logic [19:0] delay;
   logic        cfg_req;
   logic        trig_seen;
   logic [15:0] trig_count;
   logic        evt_last;
   logic        rd_done;
   logic [1:0]  next_ctrl;
   logic [15:0] next_care;
   logic [15:0] next_value;
   logic [7:0]  next_offset;
   logic [19:0] next_delay;
   logic        next_cfg_req;
   logic        next_trig_seen;
   logic [15:0] next_trig_count;
   logic        next_rd_done;
   logic [31:0] next_readdata;
   logic [31:0] rd_mux;
   logic        ack_sys;
   logic        evt_sys;
   logic        busy;
   logic        wr_take;
   logic        evt_new;

   // A configuration change is in flight until the link side echoes the toggle.
   assign busy    = (cfg_req != ack_sys);
   assign evt_new = (evt_sys != evt_last);

   // Config writes stall while the previous snapshot is crossing, so the words the
   // link side copies never change under it. If the bit clock stops, such a write
   // waits until it runs again; reads and status writes never wait on the link.
   assign avs_waitrequest = (avs_read && !rd_done) || (avs_write && busy && spt_is_cfg(avs_address));
   assign wr_take         = avs_write && !avs_waitrequest;

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `SPT_REG_CTRL:   rd_mux[1:0]  = ctrl;
         `SPT_REG_CARE:   rd_mux[15:0] = care;
         `SPT_REG_VALUE:  rd_mux[15:0] = value;
         `SPT_REG_OFFSET: rd_mux[7:0]  = offset;
         `SPT_REG_DELAY:  rd_mux[19:0] = delay;
         `SPT_REG_STATUS: begin
            rd_mux[`SPT_STAT_BUSY_BIT] = busy;
            rd_mux[`SPT_STAT_TRIG_BIT] = trig_seen;
         end
         `SPT_REG_COUNT:  rd_mux[15:0] = trig_count;
         default:         rd_mux       = 32'h0000_0000;
      endcase
   end

   // Next values of the register file and the bus answer.
   always_comb begin
      next_ctrl       = ctrl;
      next_care       = care;
      next_value      = value;
      next_offset     = offset;
      next_delay      = delay;
      next_cfg_req    = cfg_req;
      next_trig_seen  = trig_seen;
      next_trig_count = trig_count;
      next_rd_done    = avs_read && !rd_done;
      next_readdata   = (avs_read && !rd_done) ? rd_mux : avs_readdata;
      if (wr_take) begin
         case (avs_address)
            `SPT_REG_CTRL:   next_ctrl   = avs_writedata[1:0];
            `SPT_REG_CARE:   next_care   = avs_writedata[15:0];
            `SPT_REG_VALUE:  next_value  = avs_writedata[15:0];
            `SPT_REG_OFFSET: next_offset = avs_writedata[7:0];
            `SPT_REG_DELAY: begin
               // Out-of-range settings are clamped into the legal span.
               if (avs_writedata[19:0] < `SPT_DELAY_MIN) begin
                  next_delay = `SPT_DELAY_MIN;                  // see RULE6
               end else if (avs_writedata[31:20] != 12'h000 || avs_writedata[19:0] > `SPT_DELAY_MAX) begin
                  next_delay = `SPT_DELAY_MAX;
               end else begin
                  next_delay = avs_writedata[19:0];
               end
            end
            `SPT_REG_STATUS: begin
               if (avs_writedata[`SPT_STAT_TRIG_BIT]) begin
                  next_trig_seen = 1'b0;
               end
            end
            default: begin
               next_ctrl = ctrl;
            end
         endcase
         if (spt_is_cfg(avs_address)) begin
            next_cfg_req = !cfg_req;
         end
      end
      // A trigger arriving with the clear still sets the flag.
      if (evt_new) begin
         next_trig_seen  = 1'b1;
         next_trig_count = trig_count + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl         <= `SPT_CTRL_RST;
         care         <= `SPT_CARE_RST;
         value        <= `SPT_VALUE_RST;
         offset       <= `SPT_OFFSET_RST;
         delay        <= `SPT_DELAY_RST;
         cfg_req      <= 1'b0;
         trig_seen    <= 1'b0;
         trig_count   <= `SPT_COUNT_RST;
         evt_last     <= 1'b0;
         rd_done      <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ctrl         <= next_ctrl;
         care         <= next_care;
         value        <= next_value;
         offset       <= next_offset;
         delay        <= next_delay;
         cfg_req      <= next_cfg_req;
         trig_seen    <= next_trig_seen;
         trig_count   <= next_trig_count;
         evt_last     <= evt_sys;
         rd_done      <= next_rd_done;
         avs_readdata <= next_readdata;
      end
   end

   chk_write_stall: assert property (@(posedge clk) disable iff (reset)
      (avs_write && busy && spt_is_cfg(avs_address)) |-> avs_waitrequest ##1 $stable(delay))
      else $error("config write accepted while snapshot in flight");

   // ------------------------------------------------------------------
   // Crossings between the two clocks.
   // ------------------------------------------------------------------
   logic l_reset;
   logic l_req;
   logic l_ack;
   logic l_evt;

   spt_sync u_sync_rst (.clk(bit_clk), .d(reset),   .q(l_reset));
   spt_sync u_sync_req (.clk(bit_clk), .d(cfg_req), .q(l_req));
   spt_sync u_sync_ack (.clk(clk),     .d(l_ack),   .q(ack_sys));
   spt_sync u_sync_evt (.clk(clk),     .d(l_evt),   .q(evt_sys));

   // ------------------------------------------------------------------
   // Bit clock domain: snapshot, shift register, compare, framing gate.
   // ------------------------------------------------------------------
   logic [1:0]     l_ctrl;
   logic [15:0]    l_care;
   logic [15:0]    l_value;
   logic [7:0]     l_offset;
   logic [19:0]    l_delay;
   logic [15:0]    sreg;
   logic           fp_last;
   spt_frm_state_t frm_state;
   logic [7:0]     fcnt;
   logic           recog;
   logic [1:0]     next_l_ctrl;
   logic [15:0]    next_l_care;
   logic [15:0]    next_l_value;
   logic [7:0]     next_l_offset;
   logic [19:0]    next_l_delay;
   logic           next_l_ack;
   logic [15:0]    next_sreg;
   spt_frm_state_t next_frm_state;
   logic [7:0]     next_fcnt;
   logic           next_recog;
   logic           next_l_evt;
   logic           frame_edge;
   logic           window;
   logic           qual_ok;
   logic           trig;

   assign frame_edge = framing_pulse && !fp_last;
   assign window     = (frm_state == SPT_FRM_COUNT) && (fcnt == l_offset);     // see RULE5
   assign qual_ok    = !l_ctrl[`SPT_CTRL_QUAL_BIT] || window;                  // see RULE4

   // Snapshot the settings when a new request toggle arrives, and echo it at the same bit clock edge.
   always_comb begin
      next_l_ctrl   = l_ctrl;
      next_l_care   = l_care;
      next_l_value  = l_value;
      next_l_offset = l_offset;
      next_l_delay  = l_delay;
      next_l_ack    = l_ack;
      if (l_req != l_ack) begin
         next_l_ctrl   = ctrl;
         next_l_care   = care;
         next_l_value  = value;
         next_l_offset = offset;
         next_l_delay  = delay;
         next_l_ack    = l_req;
      end
   end

   // Newest bit at the top; a pattern set low is seen five bits later.
   always_comb begin
      next_sreg = {serial_data, sreg[`SPT_POS_TOP:1]};                    // see RULE1, see RULE3
   end

   // Frame offset counter: each framing edge restarts from zero; the window
   // opens once, when the count equals the setting, so N spans N+1 bit clocks.
   always_comb begin
      next_frm_state = frm_state;
      next_fcnt      = fcnt;
      case (frm_state)
         SPT_FRM_WAIT: begin
            next_fcnt = fcnt;
         end
         SPT_FRM_COUNT: begin
            if (fcnt == l_offset) begin
               next_frm_state = SPT_FRM_WAIT;
            end else begin
               next_fcnt = fcnt + 8'h01;                                  // see RULE5
            end
         end
         default: begin
            next_frm_state = SPT_FRM_WAIT;
         end
      endcase
      if (frame_edge) begin
         next_frm_state = SPT_FRM_COUNT;                                  // see RULE8
         next_fcnt      = 8'h00;
      end
   end

   // Recognition is registered once per bit clock so the full compare path
   // has a whole 50 ns bit period at the top rate.
   always_comb begin
      next_recog = l_ctrl[`SPT_CTRL_ARM_BIT] && qual_ok &&
                   spt_hit(sreg, l_value, l_care);                        // see RULE2, see RULE7
      next_l_evt = trig ? !l_evt : l_evt;
   end

   always_ff @(posedge bit_clk) begin
      if (l_reset) begin
         l_ctrl    <= `SPT_CTRL_RST;
         l_care    <= `SPT_CARE_RST;
         l_value   <= `SPT_VALUE_RST;
         l_offset  <= `SPT_OFFSET_RST;
         l_delay   <= `SPT_DELAY_RST;
         l_ack     <= 1'b0;
         sreg      <= 16'h0000;
         fp_last   <= 1'b0;
         frm_state <= SPT_FRM_WAIT;
         fcnt      <= 8'h00;
         recog     <= 1'b0;
         l_evt     <= 1'b0;
      end else begin
         l_ctrl    <= next_l_ctrl;
         l_care    <= next_l_care;
         l_value   <= next_l_value;
         l_offset  <= next_l_offset;
         l_delay   <= next_l_delay;
         l_ack     <= next_l_ack;
         sreg      <= next_sreg;
         fp_last   <= framing_pulse;
         frm_state <= next_frm_state;
         fcnt      <= next_fcnt;
         recog     <= next_recog;
         l_evt     <= next_l_evt;
      end
   end

   // Delay from recognition to the output pulse, counted in bit clocks.
   spt_delay u_delay (
      .clk   (bit_clk),
      .reset (l_reset),
      .start (recog),
      .delay (l_delay),
      .trig  (trig)
   );

   assign trigger_out = trig;

   chk_shift_entry: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE1
      !l_reset |=> (sreg[15] == $past(serial_data)) && (sreg[14:0] == $past(sreg[15:1])))
      else $error("serial bit not shifted in at the top position");

   chk_pattern_hit: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE2
      recog |-> $past(spt_hit(sreg, l_value, l_care)) && $past(l_ctrl[`SPT_CTRL_ARM_BIT]))
      else $error("recognition without a full pattern match");

   chk_low_lag: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE3
      ##5 (sreg[10:0] == $past(sreg[15:5], 5)))
      else $error("low positions do not lag the top by five bits");

   chk_frame_gate: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE4
      (recog && $past(l_ctrl[`SPT_CTRL_QUAL_BIT])) |-> $past(window))
      else $error("qualified recognition outside the frame point");

   chk_frame_count: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE5
      (window && (l_offset != 8'h00)) |-> ($past(fcnt) == l_offset - 8'h01) && $past(frm_state == SPT_FRM_COUNT))
      else $error("frame window open at the wrong count");

   chk_frame_restart: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE8
      frame_edge |=> (fcnt == 8'h00) && (frm_state == SPT_FRM_COUNT))
      else $error("framing edge did not restart the offset count");

   chk_recog_rate: assert property (@(posedge bit_clk) disable iff (l_reset) // see RULE7
      (l_ctrl[`SPT_CTRL_ARM_BIT] && !l_ctrl[`SPT_CTRL_QUAL_BIT] &&
       spt_hit(sreg, l_value, l_care)) |=> recog)
      else $error("match not recognised on the next bit clock");

endmodule : spt_trigger

// ===== bench/spt_source.sv
// Model of the serial source: bit clock, data and framing, with a trigger monitor.
`timescale 1ns/100ps
module spt_source (
   output logic      bit_clk,       // Bit clock, still between bursts.
   output logic      serial_data,   // Serial data, changed while the clock is low.
   output logic      framing_pulse, // Framing pulse, one per character.
   input  wire logic trigger_out    // Trigger from the device.
);
   int first_hit;   // Cycle of the first trigger seen, 0 if none.
   int hits;        // Cycles in which the trigger was high.

   // Lines start out still, as between bursts.
   initial begin
      bit_clk = 1'b0;
      serial_data = 1'b0;
      framing_pulse = 1'b0;
   end

   // Clocks n bits; past the stream the data toggles so that no stale level can fake a pattern.
   task automatic run(input logic [31:0] s, input logic [31:0] f, input int n, input int len);
      first_hit = 0;
      hits = 0;
      #3;
      for (int i = 0; i < n; i++) begin
         serial_data = (i < len) ? s[i] : ~serial_data;
         framing_pulse = (i < len) ? f[i] : 1'b0;
         #16 bit_clk = 1'b1;
         #15;
         if (trigger_out === 1'b1) begin
            hits++;
            if (first_hit == 0) first_hit = i + 1;
         end
         #1 bit_clk = 1'b0;
      end
      // With the clock stopped the lines are released and show the inverse of their last level.
      serial_data = ~serial_data;
      framing_pulse = ~framing_pulse;
   endtask : run
endmodule : spt_source

// ===== bench/tb_serial_pattern_trigger.sv
// Self-checking bench for the serial pattern trigger.
`timescale 1ns/100ps
`include "spt_defs.svh"
module tb_serial_pattern_trigger;
   typedef struct {
      logic [15:0] care;
      logic [15:0] value;
      logic        qual;
      logic [7:0]  offset;
      logic [19:0] delay;
      logic [31:0] stream;
      logic [31:0] frame;
      int          hit;
   } spt_row_t;

   logic        clk;
   logic        reset;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        bit_clk;
   logic        serial_data;
   logic        framing_pulse;
   logic        trigger_out;
   int          fail_count;
   int          checks_done;
   int          cycles;
   spt_row_t    rows [6];

   spt_trigger spt_trigger_inst (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bit_clk(bit_clk), .serial_data(serial_data),
      .framing_pulse(framing_pulse), .trigger_out(trigger_out));
   spt_source spt_source_inst (.bit_clk(bit_clk), .serial_data(serial_data), .framing_pulse(framing_pulse),
      .trigger_out(trigger_out));

   // Register clock, 50 ns period.
   initial clk = 1'b0;
   always #25 clk = ~clk;

   // Hang guard: the whole run needs under two thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_int(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: trigger figure %0d, expected %0d", $time, got, exp);
      end
   endtask : check_int

   // One bus transfer, held until waitrequest is seen low; read data are taken at that edge.
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // A write needs the bit clock running so that the setting can cross to the link.
   task automatic cfg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      fork
         bus(a, 1'b1, d, q);
         spt_source_inst.run(32'h0000_0000, 32'h0000_0000, 40, 0);
      join
   endtask : cfg

   task automatic reg_check(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0000_0000, q);
      check_reg(q, exp);
   endtask : reg_check

   // Main sequence: reset, register defaults, table of patterns, then the awkward cases.
   initial begin
      logic [31:0] q;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      rows = '{
         '{16'hFFFF, 16'hC3A5, 1'b0, 8'h00, 20'h0_0001, 32'hC3A5_5555, 32'h0000_0000, 34},
         '{16'hFFFF, 16'hC3A5, 1'b0, 8'h00, 20'h0_0084, 32'hC3A5_5555, 32'h0000_0000, 165},
         '{16'hFFE0, 16'hCCC0, 1'b0, 8'h00, 20'h0_0001, 32'hAE66_5555, 32'h0000_0000, 29},
         '{16'h07FF, 16'h0666, 1'b0, 8'h00, 20'h0_0001, 32'hAE66_5555, 32'h0000_0000, 34},
         '{16'hFFE0, 16'hCCC0, 1'b1, 8'h0A, 20'h0_0001, 32'hAE66_5555, 32'h0001_0000, 29},
         '{16'hFFE0, 16'hCCC0, 1'b1, 8'h09, 20'h0_0001, 32'hAE66_5555, 32'h0001_0000, 0}
      };
      // The link reset is carried over by bit clock edges, so the source clocks during reset.
      fork
         begin
            repeat (5) @(posedge clk);
            reset <= 1'b0;
         end
         spt_source_inst.run(32'h0000_0000, 32'h0000_0000, 12, 0);
      join
      for (int a = 0; a < 8; a++) begin
         reg_check(5'(a * 4), (a == 4) ? 32'h0000_0001 : 32'h0000_0000);
      end
      cfg(`SPT_REG_DELAY, 32'h0000_0000);
      reg_check(`SPT_REG_DELAY, 32'h0000_0001);
      cfg(`SPT_REG_DELAY, 32'hFFFF_FFFF);
      reg_check(`SPT_REG_DELAY, 32'h000F_423F);
      foreach (rows[i]) begin
         cfg(`SPT_REG_CARE, {16'h0000, rows[i].care});
         cfg(`SPT_REG_VALUE, {16'h0000, rows[i].value});
         cfg(`SPT_REG_OFFSET, {24'h00_0000, rows[i].offset});
         cfg(`SPT_REG_DELAY, {12'h000, rows[i].delay});
         cfg(`SPT_REG_CTRL, {30'h0000_0000, 1'b1, rows[i].qual});
         spt_source_inst.run(rows[i].stream, rows[i].frame, 200, 32);
         check_int(spt_source_inst.first_hit, rows[i].hit);
         check_int(spt_source_inst.hits, (rows[i].hit != 0) ? 1 : 0);
      end
      // Back-to-back config writes: the second stalls until the first has crossed to the link.
      fork
         begin
            bus(`SPT_REG_DELAY, 1'b1, 32'h0000_0005, q);
            bus(`SPT_REG_DELAY, 1'b1, 32'h0000_0007, q);
         end
         spt_source_inst.run(32'h0000_0000, 32'h0000_0000, 40, 0);
      join
      reg_check(`SPT_REG_DELAY, 32'h0000_0007);
      // Five triggers fired; the count is read-only and the sticky flag clears on a written one.
      reg_check(`SPT_REG_COUNT, 32'h0000_0005);
      cfg(`SPT_REG_COUNT, 32'h0000_0000);
      reg_check(`SPT_REG_COUNT, 32'h0000_0005);
      reg_check(`SPT_REG_STATUS, 32'h0000_0002);
      cfg(`SPT_REG_STATUS, 32'h0000_0002);
      reg_check(`SPT_REG_STATUS, 32'h0000_0000);
      final_report();
   end
endmodule : tb_serial_pattern_trigger
